// *** gdsl_pkg.sv ***
// Purpose: Constants for the pin direction and sense-hit latch block
// Assumes: 32 pins, 32-bit register port, byte addresses
// Notes: Pin config words sit at a base plus four times the pin index
package gdsl_pkg;
    localparam int NPINS = 32;
    localparam int AW = 12;
    localparam logic [11:0] OFS_DIR = 12'h014;
    localparam logic [11:0] OFS_DIRECTION_SET_ALIAS = 12'h018;
    localparam logic [11:0] OFS_DIRECTION_CLEAR_ALIAS = 12'h01C;
    localparam logic [11:0] OFS_HIT = 12'h020;
    localparam logic [11:0] OFS_SEL_NS = 12'h024;
    localparam logic [11:0] OFS_SEL_S = 12'h028;
    localparam logic [11:0] OFS_SECURE = 12'h02C;
    localparam logic [11:0] OFS_CNF_BASE = 12'h200;
    localparam logic [11:0] OFS_CNF_LAST = 12'h27C;
    localparam logic [31:0] RST_DIR = 32'h0000_0000;
    localparam logic [31:0] RST_HIT = 32'h0000_0000;
    localparam logic RST_SEL = 1'h0;
    localparam logic [31:0] RST_SECURE = 32'h0000_0000;
    localparam logic [31:0] RST_CNF = 32'h0000_0002;
    localparam int CNF_DIR_BIT = 0;
    localparam int CNF_SENSE_LSB = 16;
    localparam int CNF_SENSE_MSB = 17;
    localparam logic [31:0] CNF_MASK = 32'h0003_070F;
    localparam logic [1:0] SENSE_OFF = 2'h0;
    localparam logic [1:0] SENSE_HIGH = 2'h2;
    localparam logic [1:0] SENSE_LOW = 2'h3;
endpackage

// *** gdsl_pin_sense.sv ***
// Purpose: Per-pin sense compare
// Assumes: Pin level synchronous to clk_sys
// Notes: Registered detect output
`timescale 1ns/1ps
module gdsl_pin_sense (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic pin_level,
    input wire logic [1:0] sense_mode,
    output logic detect
);
    logic detect_r;
    logic detect_nxt;

    always_comb begin
        detect_nxt = 1'b0;
        if (sense_mode == gdsl_pkg::SENSE_HIGH) begin
            detect_nxt = pin_level;
        end else if (sense_mode == gdsl_pkg::SENSE_LOW) begin
            detect_nxt = ~pin_level;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            detect_r <= 1'b0;
        end else begin
            detect_r <= detect_nxt;
        end
    end

    assign detect = detect_r;
endmodule

// *** gdsl_gpio_direction_sense_latch.sv ***
// Purpose: Pin direction, sense-hit latch and detect output selection
// Assumes: Single clock, plain register port, read data one cycle later
// Notes: Retention is modelled as ordinary flops kept through power states
// Behaviour
// - Thirty-two direction bits, 0 input, 1 output, reset to zero.
// - Direction, hit flags and both selects are retained state.
// - Set alias: ones make pins outputs, zeros leave them alone.
// - Reading set or clear alias returns the direction register.
// - Clear alias: ones make pins inputs, zeros leave them alone.
// - Hit flag sets when pin meets its configured sense criterion.
// - Writing one clears a hit flag; zeros leave flags unchanged.
// - Select zero: detect output follows raw combined pin detects.
// - Select one: detect output derives from latched hit flags.
// - Non-secure select governs only the non-secure detect output.
// - Secure select governs only the secure detect output, independently.
// - Sense field: 0 disabled, 2 high level, 3 low level.
// - Config word direction bit shares storage with direction register.
`timescale 1ns/1ps
module gdsl_gpio_direction_sense_latch #(
    parameter int NPINS = gdsl_pkg::NPINS
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [NPINS-1:0] pin_level,
    output logic [NPINS-1:0] pin_dir,
    output logic detect_nonsecure,
    output logic detect_secure
);
    // ****************************************
    // State
    // ****************************************
    logic [31:0] dir_r, dir_nxt;
    logic [31:0] hit_r, hit_nxt;
    logic sel_ns_r, sel_ns_nxt;
    logic sel_s_r, sel_s_nxt;
    logic [31:0] secure_r, secure_nxt;
    logic [31:0] cnf_r [NPINS];
    logic [31:0] cnf_nxt [NPINS];
    logic [31:0] rdata_r, rdata_nxt;
    logic det_ns_r, det_ns_nxt;
    logic det_s_r, det_s_nxt;
    logic [NPINS-1:0] pin_det;
    logic [NPINS-1:0] hit_clr;
    logic clr_pulse;
    logic cnf_hit;
    logic [4:0] cnf_idx;

    // ****************************************
    // Per-pin sense compare
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : g_pin
            gdsl_pin_sense u_sense (
                .clk_sys(clk_sys),
                .rstn(rstn),
                .pin_level(pin_level[g]),
                .sense_mode(cnf_r[g][gdsl_pkg::CNF_SENSE_MSB:gdsl_pkg::CNF_SENSE_LSB]),
                .detect(pin_det[g])
            );
        end
    endgenerate

    assign cnf_hit = (reg_addr >= gdsl_pkg::OFS_CNF_BASE) && (reg_addr <= gdsl_pkg::OFS_CNF_LAST)
        && (reg_addr[1:0] == 2'h0);
    assign cnf_idx = 5'(reg_addr[11:2] - gdsl_pkg::OFS_CNF_BASE[11:2]);

    // ****************************************
    // Register writes and hit latching
    // ****************************************
    always_comb begin
        dir_nxt = dir_r;
        sel_ns_nxt = sel_ns_r;
        sel_s_nxt = sel_s_r;
        secure_nxt = secure_r;
        hit_clr = '0;
        clr_pulse = 1'b0;
        for (int i = 0; i < NPINS; i++) begin
            cnf_nxt[i] = cnf_r[i];
        end
        if (reg_wr) begin
            unique case (reg_addr)
                gdsl_pkg::OFS_DIR: dir_nxt = reg_wdata;
                gdsl_pkg::OFS_DIRECTION_SET_ALIAS: dir_nxt = dir_r | reg_wdata;
                gdsl_pkg::OFS_DIRECTION_CLEAR_ALIAS: dir_nxt = dir_r & ~reg_wdata;
                gdsl_pkg::OFS_HIT: begin
                    hit_clr = reg_wdata[NPINS-1:0];
                    clr_pulse = |reg_wdata[NPINS-1:0];
                end
                gdsl_pkg::OFS_SEL_NS: sel_ns_nxt = reg_wdata[0];
                gdsl_pkg::OFS_SEL_S: sel_s_nxt = reg_wdata[0];
                gdsl_pkg::OFS_SECURE: secure_nxt = reg_wdata;
                default: begin
                    if (cnf_hit) begin
                        cnf_nxt[cnf_idx] = reg_wdata & gdsl_pkg::CNF_MASK;
                        dir_nxt[cnf_idx] = reg_wdata[gdsl_pkg::CNF_DIR_BIT];
                    end
                end
            endcase
        end
        // Set wins over a clear in the same cycle
        hit_nxt = (hit_r & ~hit_clr) | pin_det;
    end

    // ****************************************
    // Detect outputs
    // ****************************************
    always_comb begin
        logic [31:0] held_ns;
        logic [31:0] held_s;
        held_ns = hit_r & ~secure_r;
        held_s = hit_r & secure_r;
        // Drop for one cycle on a clear so surviving flags give a new edge
        if (sel_ns_r) begin
            det_ns_nxt = |held_ns && !clr_pulse;
        end else begin
            det_ns_nxt = |(pin_det & ~secure_r);
        end
        if (sel_s_r) begin
            det_s_nxt = |held_s && !clr_pulse;
        end else begin
            det_s_nxt = |(pin_det & secure_r);
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (reg_rd) begin
            unique case (reg_addr)
                gdsl_pkg::OFS_DIR: rdata_nxt = dir_r;
                gdsl_pkg::OFS_DIRECTION_SET_ALIAS: rdata_nxt = dir_r;
                gdsl_pkg::OFS_DIRECTION_CLEAR_ALIAS: rdata_nxt = dir_r;
                gdsl_pkg::OFS_HIT: rdata_nxt = hit_r;
                gdsl_pkg::OFS_SEL_NS: rdata_nxt = {31'h0, sel_ns_r};
                gdsl_pkg::OFS_SEL_S: rdata_nxt = {31'h0, sel_s_r};
                gdsl_pkg::OFS_SECURE: rdata_nxt = secure_r;
                default: begin
                    if (cnf_hit) begin
                        rdata_nxt = cnf_r[cnf_idx];
                        rdata_nxt[gdsl_pkg::CNF_DIR_BIT] = dir_r[cnf_idx];
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Registers (retained state)
    // ****************************************
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dir_r <= gdsl_pkg::RST_DIR;
            hit_r <= gdsl_pkg::RST_HIT;
            sel_ns_r <= gdsl_pkg::RST_SEL;
            sel_s_r <= gdsl_pkg::RST_SEL;
            secure_r <= gdsl_pkg::RST_SECURE;
            rdata_r <= 32'h0000_0000;
            det_ns_r <= 1'b0;
            det_s_r <= 1'b0;
            for (int i = 0; i < NPINS; i++) begin
                cnf_r[i] <= gdsl_pkg::RST_CNF;
            end
        end else begin
            dir_r <= dir_nxt;
            hit_r <= hit_nxt;
            sel_ns_r <= sel_ns_nxt;
            sel_s_r <= sel_s_nxt;
            secure_r <= secure_nxt;
            rdata_r <= rdata_nxt;
            det_ns_r <= det_ns_nxt;
            det_s_r <= det_s_nxt;
            for (int i = 0; i < NPINS; i++) begin
                cnf_r[i] <= cnf_nxt[i];
            end
        end
    end

    assign reg_rdata = rdata_r;
    assign pin_dir = dir_r;
    assign detect_nonsecure = det_ns_r;
    assign detect_secure = det_s_r;
endmodule

// *** gdsl_chk.sv ***
// Purpose: Port checks for the direction and sense-hit block
// Assumes: One clock, selects in bit 0
// Notes: Selects mirrored in helper flops
`timescale 1ns/1ps
module gdsl_chk #(parameter int NPINS = 32) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [NPINS-1:0] pin_level,
    input wire logic [NPINS-1:0] pin_dir,
    input wire logic detect_nonsecure,
    input wire logic detect_secure
);
    logic sns_r;
    logic ss_r;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sns_r <= 1'h0;
            ss_r <= 1'h0;
        end else if (reg_wr && reg_addr == 12'h024) begin
            sns_r <= reg_wdata[0];
        end else if (reg_wr && reg_addr == 12'h028) begin
            ss_r <= reg_wdata[0];
        end
    end
    sequence s_hit_clr;
        reg_wr && reg_addr == 12'h020 && reg_wdata != 32'h0;
    endsequence
    chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not zero");
    chk_dir_rd: assert property (reg_rd && reg_addr inside {12'h014, 12'h018, 12'h01C}
        |=> reg_rdata == $past(pin_dir)) else $error("direction read wrong");
    chk_dir_wr: assert property (reg_wr && reg_addr == 12'h014
        |=> pin_dir == $past(reg_wdata)) else $error("direction write wrong");
    chk_dir_set: assert property (reg_wr && reg_addr == 12'h018
        |=> pin_dir == ($past(pin_dir) | $past(reg_wdata))) else $error("set alias wrong");
    chk_dir_clr: assert property (reg_wr && reg_addr == 12'h01C
        |=> pin_dir == ($past(pin_dir) & ~$past(reg_wdata))) else $error("clear alias wrong");
    chk_dir_hold: assert property (!reg_wr |=> $stable(pin_dir))
        else $error("direction changed without write");
    chk_ns_drop: assert property (sns_r throughout s_hit_clr |=> !detect_nonsecure)
        else $error("non-secure output did not drop");
    chk_s_drop: assert property (ss_r throughout s_hit_clr |=> !detect_secure)
        else $error("secure output did not drop");
endmodule
bind gdsl_gpio_direction_sense_latch gdsl_chk #(.NPINS(NPINS)) i_chk (.clk_sys(clk_sys),
    .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_level(pin_level), .pin_dir(pin_dir),
    .detect_nonsecure(detect_nonsecure), .detect_secure(detect_secure));

// *** test_gpio_direction_sense_latch.sv ***
// Purpose: Self-checking bench for the direction and sense-hit block
// Assumes: 40 MHz clock, read data one cycle after strobe
// Notes: Direction model kept in m_dir
`timescale 1ns/1ps
module test_gpio_direction_sense_latch;
    logic clk_sys = 1'h0;
    logic rstn = 1'h0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [31:0] reg_rdata;
    logic [31:0] lvl = 32'h0;
    logic [31:0] pin_dir;
    logic det_ns;
    logic det_s;
    logic [31:0] v;
    logic [31:0] m_dir = 32'h0;
    int err_count = 0;
    int cmp_count = 0;
    always #12.5 clk_sys = ~clk_sys;
    gdsl_gpio_direction_sense_latch i_dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_level(lvl), .pin_dir(pin_dir), .detect_nonsecure(det_ns), .detect_secure(det_s));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
        @(posedge clk_sys);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        @(negedge clk_sys);
        chk(n, reg_rdata, e);
    endtask
    task automatic cy(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Watchdog: run needs about 110 cycles
    initial begin
        #50000;
        err_count++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'hdcaf6007));
        repeat (6) @(posedge clk_sys);
        rstn <= 1'h1;
        for (int i = 0; i < 6; i++) rd(12'h014 + 12'(i * 4), 32'h0, "reset value");
        rd(12'h0FC, 32'h0, "unmapped");
        $display("reset test done");
        for (int i = 0; i < 9; i++) begin
            v = $urandom();
            wr(12'h014 + 12'(4 * (i % 3)), v);
            m_dir = (i % 3 == 0) ? v : (i % 3 == 1) ? (m_dir | v) : (m_dir & ~v);
            rd(12'h014 + 12'(4 * ((i + 1) % 3)), m_dir, "dir read");
            chk("pin_dir", pin_dir, m_dir);
        end
        wr(12'h214, 32'h1);
        m_dir[5] = 1'h1;
        rd(12'h014, m_dir, "cnf dir");
        wr(12'h01C, 32'h20);
        rd(12'h214, 32'h0, "cnf word");
        $display("direction test done");
        wr(12'h20C, 32'h0002_0000);
        @(posedge clk_sys);
        lvl <= 32'h8;
        cy(3);
        chk("ns raw", {31'h0, det_ns}, 32'h1);
        chk("s raw", {31'h0, det_s}, 32'h0);
        @(posedge clk_sys);
        lvl <= 32'h0;
        cy(3);
        chk("ns raw low", {31'h0, det_ns}, 32'h0);
        rd(12'h020, 32'h8, "hit flags");
        wr(12'h024, 32'h1);
        cy(3);
        chk("ns latched", {31'h0, det_ns}, 32'h1);
        wr(12'h020, 32'h8);
        cy(3);
        chk("ns cleared", {31'h0, det_ns}, 32'h0);
        rd(12'h020, 32'h0, "hit cleared");
        $display("non-secure test done");
        wr(12'h02C, 32'h88);
        wr(12'h028, 32'h1);
        wr(12'h21C, 32'h0003_0000);
        @(posedge clk_sys);
        lvl <= 32'h8;
        @(posedge clk_sys);
        lvl <= 32'h80;
        cy(3);
        chk("s latched", {31'h0, det_s}, 32'h1);
        chk("ns idle", {31'h0, det_ns}, 32'h0);
        rd(12'h020, 32'h88, "two flags");
        wr(12'h020, 32'h8);
        rd(12'h020, 32'h80, "one flag");
        chk("s refire", {31'h0, det_s}, 32'h1);
        $display("secure test done");
        give_verdict();
    end
endmodule
